// file: core/ecpf_core.sv
// fifo, mode selection and extended control core of the ecp parallel port
`timescale 1ns/1ps

// Notes on behaviour
// - mode 010 sends fifo bytes forward with the standard strobe handshake
// - mode 011 forward sends fifo bytes with the ecp handshake automatically
// - mode 011 reverse collects peripheral bytes into the fifo for host reads
// - mode 110 fifo is host accessible both ways, never strobed out
// - first configuration register always reads 10h
// - second configuration register bit 7 reads zero, writes ignored
// - bit 6 of second configuration register shows the bus irq line level
// - bits 5..3 of second configuration register hold the irq selection code
// - low three bits of second configuration register read ones, ignore writes
// - extended control top bits select mode; mode 000 clears the fifo
// - mode 001 lets direction float data lines; data reads return line levels
// - mode 011 command and data windows share one ordered queue
// - mode 100 active only with enhanced option; 101 reserved
// - mode 111 maps configuration registers at 400h and 401h
// - fault mask bit gates fault pulses, including on clearing while asserted
// - dma allow bit enables dma; zero disables it unconditionally
// - service flag blocks dma and service irqs; hardware sets, software clears
// - flag set on terminal count with dma, else on fifo thresholds
// - full bit reads one when no entry is free
// - empty bit reads one when fifo holds nothing
// - all windows share one 16-entry byte fifo
// - status, control and extended control reachable in every mode
// - only modes 000 and 001 may change to any mode; others may only go back to 000 or 001
// - direction ignored in modes 000 and 010; elsewhere one means input
// - dma request pin asserts while dma allowed and fifo needs service
module ecpf_core #(
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire ecpf_pkg::ecpf_host_type i_host,
  output logic [7:0] o_io_rdata,
  output logic o_dma_request_pin,
  output logic o_service_irq,
  output logic o_fault_irq,
  output logic o_epp_active,
  input wire logic i_epp_option,
  input wire logic [AW:0] i_free_space_level,
  input wire logic [AW:0] i_fill_level,
  input wire logic [7:0] i_pd,
  input wire logic i_busy,
  input wire logic i_ack_n,
  input wire logic i_peripheral_fault_n,
  input wire logic i_perror,
  input wire logic i_select,
  input wire logic i_irq_line_sample,
  output ecpf_pkg::ecpf_line_type o_line
);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("fifo depth must be a power of two of at least 2");
    end
  end

  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  ////////////////////////////////////////////////////////////////////////
  // state record and decode helpers

  typedef struct packed {
    logic [ecpf_pkg::PIN_W-1:0] s1;
    logic [ecpf_pkg::PIN_W-1:0] s2;
    logic [ecpf_pkg::PIN_W-1:0] s3;
    logic [ecpf_pkg::PIN_W-1:0] filt;
    ecpf_pkg::ecpf_mode_type mode;
    logic [5:0] ctl;
    logic [7:0] latch;
    logic [2:0] irq_sel;
    logic mask;
    logic dma;
    logic svc;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    ecpf_pkg::ecpf_xfer_type xf;
    logic [7:0] tx_byte;
    logic tx_cmd;
    logic [7:0] rdata;
    logic svc_irq;
    logic fault_irq;
  } ecpf_state_type;

  ecpf_state_type r_reg;
  ecpf_state_type r_next;
  logic push;
  logic pop;
  logic [8:0] push_data;
  logic [8:0] mem_rd;
  logic dir;
  logic full;
  logic empty;
  logic fifo_md;
  logic hst_fifo;
  logic svc_event;

  // modes that move bytes through the shared fifo
  function automatic logic is_fifo_mode(input ecpf_pkg::ecpf_mode_type m);
    return m == ecpf_pkg::MODE_COMPAT_FIFO_WINDOW || m == ecpf_pkg::MODE_ECP || m == ecpf_pkg::MODE_TEST;
  endfunction

  function automatic logic is_plain_mode(input logic [2:0] m);
    return m == ecpf_pkg::MODE_STD || m == ecpf_pkg::MODE_BIDIR;
  endfunction

  // direction has no effect where the lines always drive out
  always_comb begin
    dir = r_reg.ctl[ecpf_pkg::CTL_DIR];
    if (r_reg.mode == ecpf_pkg::MODE_STD || r_reg.mode == ecpf_pkg::MODE_COMPAT_FIFO_WINDOW) begin
      dir = 1'b0;
    end
  end

  assign full = r_reg.cnt == FULL_CNT;
  assign empty = r_reg.cnt == '0;
  assign fifo_md = is_fifo_mode(r_reg.mode);
  // dma cycles always target the data fifo window
  assign hst_fifo = i_host.dma_ack ||
    (i_host.addr == ecpf_pkg::OFF_FIFO && r_reg.mode != ecpf_pkg::MODE_CONFIG);

  // service event: terminal count under dma, otherwise threshold levels
  always_comb begin
    svc_event = 1'b0;
    if (fifo_md && !r_reg.svc) begin
      if (r_reg.dma) begin
        svc_event = i_host.dma_ack && i_host.dma_tc;
      end else if (!dir) begin
        svc_event = (FULL_CNT - r_reg.cnt) >= i_free_space_level;
      end else begin
        svc_event = r_reg.cnt >= i_fill_level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_next = r_reg;
    r_next.svc_irq = 1'b0;
    r_next.fault_irq = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_data = '0;
    // three-stage pin synchroniser; a change counts once stages two and three agree
    r_next.s1 = {i_select, i_perror, i_irq_line_sample, i_peripheral_fault_n,
                 i_ack_n, i_busy, i_pd};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.filt = ((r_reg.s2 ~^ r_reg.s3) & r_reg.s3) | ((r_reg.s2 ^ r_reg.s3) & r_reg.filt);

    // host writes
    if (i_host.wr) begin
      if (hst_fifo) begin
        // one shared queue for every window; writes to a full fifo are dropped
        if (!full && (r_reg.mode == ecpf_pkg::MODE_COMPAT_FIFO_WINDOW || r_reg.mode == ecpf_pkg::MODE_TEST ||
            (r_reg.mode == ecpf_pkg::MODE_ECP && !dir))) begin
          push = 1'b1;
          push_data = {1'b0, i_host.wdata};
        end
      end else begin
        unique case (i_host.addr)
          ecpf_pkg::OFF_DATA: begin
            if (r_reg.mode == ecpf_pkg::MODE_ECP) begin
              if (!dir && !full) begin
                push = 1'b1;
                push_data = {1'b1, i_host.wdata};
              end
            end else begin
              r_next.latch = i_host.wdata;
            end
          end
          ecpf_pkg::OFF_CONTROL: begin
            r_next.ctl = i_host.wdata[5:0];
          end
          ecpf_pkg::OFF_CFGB: begin
            if (r_reg.mode == ecpf_pkg::MODE_CONFIG) begin
              r_next.irq_sel = i_host.wdata[ecpf_pkg::CFGB_IRQ_LSB +: 3];
            end
          end
          ecpf_pkg::OFF_ECR: begin
            // leaving a non-plain mode is only allowed back into 000 or 001
            if (is_plain_mode(r_reg.mode) ||
                is_plain_mode(i_host.wdata[ecpf_pkg::ECR_MODE_LSB +: 3])) begin
              r_next.mode = ecpf_pkg::ecpf_mode_type'(
                i_host.wdata[ecpf_pkg::ECR_MODE_LSB +: 3]);
            end
            r_next.mask = i_host.wdata[ecpf_pkg::ECR_MASK_BIT];
            r_next.dma = i_host.wdata[ecpf_pkg::ECR_DMA_BIT];
            r_next.svc = i_host.wdata[ecpf_pkg::ECR_SVC_BIT];
            // clearing the mask while the fault is already low raises a pulse
            if (r_reg.mode == ecpf_pkg::MODE_ECP && r_reg.mask &&
                !i_host.wdata[ecpf_pkg::ECR_MASK_BIT] && !r_reg.filt[ecpf_pkg::PIN_FAULT]) begin
              r_next.fault_irq = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // host reads; answer is registered
    if (i_host.rd) begin
      r_next.rdata = '0;
      if (hst_fifo) begin
        r_next.rdata = mem_rd[7:0];
        if (!empty && (r_reg.mode == ecpf_pkg::MODE_TEST ||
            (r_reg.mode == ecpf_pkg::MODE_ECP && dir))) begin
          pop = 1'b1;
        end
      end else begin
        unique case (i_host.addr)
          ecpf_pkg::OFF_DATA: begin
            r_next.rdata = (r_reg.mode == ecpf_pkg::MODE_BIDIR) ?
              r_reg.filt[7:0] : r_reg.latch;
          end
          ecpf_pkg::OFF_STATUS: begin
            r_next.rdata = {~r_reg.filt[ecpf_pkg::PIN_BUSY], r_reg.filt[ecpf_pkg::PIN_ACK],
              r_reg.filt[ecpf_pkg::PIN_PERR], r_reg.filt[ecpf_pkg::PIN_SEL],
              r_reg.filt[ecpf_pkg::PIN_FAULT], ecpf_pkg::LOW_ONES};
          end
          ecpf_pkg::OFF_CONTROL: begin
            r_next.rdata = {ecpf_pkg::CTL_TOP_ONES, r_reg.ctl};
          end
          ecpf_pkg::OFF_FIFO: begin
            r_next.rdata = ecpf_pkg::CFGA_VALUE;
          end
          ecpf_pkg::OFF_CFGB: begin
            if (r_reg.mode == ecpf_pkg::MODE_CONFIG) begin
              r_next.rdata = {1'b0, r_reg.filt[ecpf_pkg::PIN_IRQ], r_reg.irq_sel,
                ecpf_pkg::LOW_ONES};
            end
          end
          ecpf_pkg::OFF_ECR: begin
            r_next.rdata = {r_reg.mode, r_reg.mask, r_reg.dma, r_reg.svc,
              full, empty};
          end
          default: begin
          end
        endcase
      end
    end

    // fault pulse on the falling edge of the filtered fault line
    if (r_reg.mode == ecpf_pkg::MODE_ECP && !r_reg.mask &&
        r_reg.filt[ecpf_pkg::PIN_FAULT] && !r_next.filt[ecpf_pkg::PIN_FAULT]) begin
      r_next.fault_irq = 1'b1;
    end

    // hardware set wins over a software clear in the same cycle
    if (svc_event) begin
      r_next.svc = 1'b1;
      r_next.svc_irq = 1'b1;
    end

    // automatic line handshake
    unique case (r_reg.xf)
      ecpf_pkg::XF_IDLE: begin
        if (!empty && (r_reg.mode == ecpf_pkg::MODE_COMPAT_FIFO_WINDOW ||
            (r_reg.mode == ecpf_pkg::MODE_ECP && !dir))) begin
          pop = 1'b1;
          r_next.tx_byte = mem_rd[7:0];
          r_next.tx_cmd = mem_rd[8] && r_reg.mode == ecpf_pkg::MODE_ECP;
          r_next.xf = ecpf_pkg::XF_SETUP;
        end else if (!full && r_reg.mode == ecpf_pkg::MODE_ECP && dir) begin
          r_next.xf = ecpf_pkg::XF_RXREQ;
        end
      end
      ecpf_pkg::XF_SETUP: begin
        if (!r_reg.filt[ecpf_pkg::PIN_BUSY]) begin
          r_next.xf = ecpf_pkg::XF_STROBE;
        end
      end
      ecpf_pkg::XF_STROBE: begin
        if (r_reg.filt[ecpf_pkg::PIN_BUSY]) begin
          r_next.xf = ecpf_pkg::XF_DONE;
        end
      end
      ecpf_pkg::XF_DONE: begin
        if (!r_reg.filt[ecpf_pkg::PIN_BUSY]) begin
          r_next.xf = ecpf_pkg::XF_IDLE;
        end
      end
      ecpf_pkg::XF_RXREQ: begin
        // busy low while the peripheral clocks marks a command byte
        if (!r_reg.filt[ecpf_pkg::PIN_ACK]) begin
          push = 1'b1;
          push_data = {~r_reg.filt[ecpf_pkg::PIN_BUSY], r_reg.filt[7:0]};
          r_next.xf = ecpf_pkg::XF_RXACK;
        end
      end
      ecpf_pkg::XF_RXACK: begin
        if (r_reg.filt[ecpf_pkg::PIN_ACK]) begin
          r_next.xf = ecpf_pkg::XF_IDLE;
        end
      end
      default: begin
        r_next.xf = ecpf_pkg::XF_IDLE;
      end
    endcase

    // pointer and count bookkeeping
    if (push) begin
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    r_next.cnt = r_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);

    // a transfer cut off by a mode change is abandoned
    if (!fifo_md || (r_reg.mode == ecpf_pkg::MODE_TEST)) begin
      r_next.xf = ecpf_pkg::XF_IDLE;
    end
    // standard mode holds the fifo cleared
    if (r_reg.mode == ecpf_pkg::MODE_STD) begin
      r_next.wp = '0;
      r_next.rp = '0;
      r_next.cnt = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register and storage

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_reg <= '0;
      r_reg.mode <= ecpf_pkg::MODE_STD;
      r_reg.xf <= ecpf_pkg::XF_IDLE;
      r_reg.irq_sel <= ecpf_pkg::CFGB_IRQ_RST;
      r_reg.svc <= 1'b1;
      r_reg.s1 <= '1;
      r_reg.s2 <= '1;
      r_reg.s3 <= '1;
      r_reg.filt <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  // read address follows the next pointer so the head byte is always current
  ecpf_fifo_mem #(
    .WIDTH(9),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_wr_en(push),
    .i_wr_addr(r_reg.wp),
    .i_wr_data(push_data),
    .i_rd_addr(r_next.rp),
    .o_rd_data(mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_io_rdata = r_reg.rdata;
  assign o_service_irq = r_reg.svc_irq;
  assign o_fault_irq = r_reg.fault_irq;
  assign o_epp_active = r_reg.mode == ecpf_pkg::MODE_EPP && i_epp_option;
  // request only while allowed, unblocked and the fifo has room or data
  assign o_dma_request_pin = r_reg.dma && !r_reg.svc && fifo_md &&
    (dir ? !empty : !full);

  // in automatic modes the handshake owns strobe, and in mode 011 also autofd
  always_comb begin
    o_line.pd = is_plain_mode(r_reg.mode) ? r_reg.latch : r_reg.tx_byte;
    o_line.pd_oe = !dir;
    o_line.strobe_n = !r_reg.ctl[ecpf_pkg::CTL_STROBE];
    o_line.autofd_n = !r_reg.ctl[ecpf_pkg::CTL_AUTOFD];
    o_line.init_n = r_reg.ctl[ecpf_pkg::CTL_INIT];
    o_line.selectin_n = !r_reg.ctl[ecpf_pkg::CTL_SELIN];
    if (r_reg.mode == ecpf_pkg::MODE_COMPAT_FIFO_WINDOW || r_reg.mode == ecpf_pkg::MODE_ECP) begin
      o_line.strobe_n = r_reg.xf != ecpf_pkg::XF_STROBE;
      if (r_reg.mode == ecpf_pkg::MODE_ECP) begin
        o_line.autofd_n = dir ? (r_reg.xf != ecpf_pkg::XF_RXREQ) : !r_reg.tx_cmd;
      end
    end else if (r_reg.mode == ecpf_pkg::MODE_TEST) begin
      o_line.strobe_n = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence s_cfg_rd(logic [10:0] a);
    i_host.rd && !i_host.dma_ack && !i_host.wr && i_host.addr == a &&
      r_reg.mode == ecpf_pkg::MODE_CONFIG;
  endsequence

  property p_cfga;
    s_cfg_rd(ecpf_pkg::OFF_FIFO) |=> o_io_rdata == ecpf_pkg::CFGA_VALUE;
  endproperty
  a_cfga: assert property (p_cfga) else $error("config A value wrong");

  property p_cfgb;
    s_cfg_rd(ecpf_pkg::OFF_CFGB) |=> !o_io_rdata[7] && o_io_rdata[2:0] == 3'h7 &&
      o_io_rdata[6] == $past(r_reg.filt[ecpf_pkg::PIN_IRQ]);
  endproperty
  a_cfgb: assert property (p_cfgb) else $error("config B fixed bits wrong");

  property p_flags;
    i_host.rd && !i_host.dma_ack && i_host.addr == ecpf_pkg::OFF_ECR |=>
      o_io_rdata[1] == ($past(r_reg.cnt) == FULL_CNT) && o_io_rdata[0] == ($past(r_reg.cnt) == 0);
  endproperty
  a_flags: assert property (p_flags) else $error("full or empty flag wrong");

  property p_std_clear;
    // drive is checked in the same cycle, since the next one may already be another mode
    r_reg.mode == ecpf_pkg::MODE_STD |-> o_line.pd_oe ##1 r_reg.cnt == 0;
  endproperty
  a_std_clear: assert property (p_std_clear) else $error("fifo not cleared");

  property p_dma_gate;
    (!r_reg.dma || r_reg.svc) |-> !o_dma_request_pin;
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("dma request while blocked");

  property p_tc;
    r_reg.dma && !r_reg.svc && fifo_md && i_host.dma_ack && i_host.dma_tc |=>
      r_reg.svc && o_service_irq ##1 !o_service_irq;
  endproperty
  a_tc: assert property (p_tc) else $error("terminal count missed");

  property p_refuse;
    i_host.wr && !i_host.dma_ack && i_host.addr == ecpf_pkg::OFF_ECR &&
      !is_plain_mode(r_reg.mode) &&
      !is_plain_mode(i_host.wdata[ecpf_pkg::ECR_MODE_LSB +: 3]) |=> $stable(r_reg.mode);
  endproperty
  a_refuse: assert property (p_refuse) else $error("illegal mode change taken");

  property p_test_quiet;
    r_reg.mode == ecpf_pkg::MODE_TEST |-> o_line.strobe_n;
  endproperty
  a_test_quiet: assert property (p_test_quiet) else $error("strobe in test mode");

  sequence s_fault_fall;
    r_reg.mode == ecpf_pkg::MODE_ECP && !r_reg.mask && !i_host.wr &&
      r_reg.filt[ecpf_pkg::PIN_FAULT] ##1 !r_reg.filt[ecpf_pkg::PIN_FAULT];
  endsequence
  property p_fault;
    s_fault_fall |-> o_fault_irq;
  endproperty
  a_fault: assert property (p_fault) else $error("fault pulse missed");

  property p_tx;
    // a host write may legally leave the mode and abandon the transfer
    r_reg.xf == ecpf_pkg::XF_SETUP && !r_reg.filt[ecpf_pkg::PIN_BUSY] && fifo_md &&
      r_reg.mode != ecpf_pkg::MODE_TEST && !i_host.wr |=> !o_line.strobe_n;
  endproperty
  a_tx: assert property (p_tx) else $error("strobe not issued");

endmodule

// file: core/ecpf_fifo_mem.sv
// byte storage of the shared fifo, registered read with write bypass
`timescale 1ns/1ps
module ecpf_fifo_mem #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // the address must reach every entry
  initial begin
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) < DEPTH) begin
      $error("fifo storage parameters out of range");
    end
  end

  // array has no reset; contents are only read after being written
  always_ff @(posedge i_mclk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // bypass lets a byte written into an empty fifo be read next cycle
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= '0;
    end else if (i_wr_en && i_wr_addr == i_rd_addr) begin
      o_rd_data <= i_wr_data;
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule

// file: core/ecpf_pkg.sv
// shared constants and types for the ecp port fifo and mode control core
package ecpf_pkg;

  // register offsets from the port base
  localparam logic [10:0] OFF_DATA = 11'h000;
  localparam logic [10:0] OFF_STATUS = 11'h001;
  localparam logic [10:0] OFF_CONTROL = 11'h002;
  localparam logic [10:0] OFF_FIFO = 11'h400;
  localparam logic [10:0] OFF_CFGB = 11'h401;
  localparam logic [10:0] OFF_ECR = 11'h402;

  // fixed and reset values
  localparam logic [7:0] CFGA_VALUE = 8'h10;
  localparam logic [2:0] CFGB_IRQ_RST = 3'h0;
  localparam logic [2:0] LOW_ONES = 3'h7;
  localparam logic [1:0] CTL_TOP_ONES = 2'h3;

  // extended control and configuration B field positions
  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_MASK_BIT = 4;
  localparam int ECR_DMA_BIT = 3;
  localparam int ECR_SVC_BIT = 2;
  localparam int CFGB_IRQ_LSB = 3;

  // line control field positions
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELIN = 3;
  localparam int CTL_DIR = 5;

  // synchronised pin vector layout
  localparam int PIN_BUSY = 8;
  localparam int PIN_ACK = 9;
  localparam int PIN_FAULT = 10;
  localparam int PIN_IRQ = 11;
  localparam int PIN_PERR = 12;
  localparam int PIN_SEL = 13;
  localparam int PIN_W = 14;

  typedef enum logic [2:0] {
    MODE_STD = 3'h0,
    MODE_BIDIR = 3'h1,
    MODE_COMPAT_FIFO_WINDOW = 3'h2,
    MODE_ECP = 3'h3,
    MODE_EPP = 3'h4,
    MODE_RSVD = 3'h5,
    MODE_TEST = 3'h6,
    MODE_CONFIG = 3'h7
  } ecpf_mode_type;

  typedef enum logic [2:0] {
    XF_IDLE = 3'h0,
    XF_SETUP = 3'h1,
    XF_STROBE = 3'h2,
    XF_DONE = 3'h3,
    XF_RXREQ = 3'h4,
    XF_RXACK = 3'h5
  } ecpf_xfer_type;

  // host register access group
  typedef struct packed {
    logic wr;
    logic rd;
    logic dma_ack;
    logic dma_tc;
    logic [10:0] addr;
    logic [7:0] wdata;
  } ecpf_host_type;

  // peripheral-facing output group
  typedef struct packed {
    logic [7:0] pd;
    logic pd_oe;
    logic strobe_n;
    logic autofd_n;
    logic init_n;
    logic selectin_n;
  } ecpf_line_type;

endpackage

// file: testbench/ecpf_periph_model.sv
// behavioural printer-class peripheral on the parallel port lines
`timescale 1ns/1ps
module ecpf_periph_model (
  input wire logic i_mclk,
  input wire ecpf_pkg::ecpf_line_type i_line,
  output logic o_busy,
  output logic o_ack_n = 1'b1,
  output logic [7:0] o_pd
);
  logic [8:0] rx [0:15];
  int n_rx = 0;
  int n_tx = 0;
  logic fbusy = 1'b0;
  logic [7:0] val = 8'h50;
  logic rev;
  ////////////////////////////////////////////////////////////////////////////////
  // busy stays high in reverse so every byte counts as data; released lines show junk
  assign rev = !i_line.pd_oe;
  assign o_busy = rev ? 1'b1 : fbusy;
  assign o_pd = o_ack_n ? ~val : val;
  // forward takes byte and tag on strobe low; reverse offers a byte while asked
  always @(posedge i_mclk) begin
    if (!rev && !i_line.strobe_n && !fbusy) begin
      rx[n_rx[3:0]] <= {~i_line.autofd_n, i_line.pd};
      n_rx <= n_rx + 1;
      fbusy <= 1'b1;
    end else if (i_line.strobe_n) begin
      fbusy <= 1'b0;
    end
    if (rev && !i_line.autofd_n && o_ack_n) begin
      o_ack_n <= 1'b0;
    end else if (!o_ack_n && (i_line.autofd_n || !rev)) begin
      o_ack_n <= 1'b1;
      val <= val + 8'h01;
      n_tx <= n_tx + 1;
    end
  end
endmodule

// file: testbench/tb.sv
// self-checking bench for the ecp port fifo and mode control core
`timescale 1ns/1ps
module tb;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  ecpf_pkg::ecpf_host_type host = '0;
  logic [7:0] rdata, mpd;
  logic dreq, svc_irq, flt_irq, epp, busy, ack_n;
  logic epp_opt = 1'b0;
  logic fault_n = 1'b1;
  logic irq_s = 1'b1;
  ecpf_pkg::ecpf_line_type line;
  logic [8:0] fexp [0:4] = '{9'h011, 9'h022, 9'h033, 9'h1A5, 9'h03C};
  int mismatches = 0;
  int n_checks = 0;
  int n_svc = 0;
  int n_flt = 0;
  ecpf_core ecpf_core_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_host(host),
    .o_io_rdata(rdata), .o_dma_request_pin(dreq), .o_service_irq(svc_irq),
    .o_fault_irq(flt_irq), .o_epp_active(epp), .i_epp_option(epp_opt),
    .i_free_space_level(5'h10), .i_fill_level(5'h10), .i_pd(line.pd_oe ? line.pd : mpd),
    .i_busy(busy), .i_ack_n(ack_n), .i_peripheral_fault_n(fault_n), .i_perror(1'b1),
    .i_select(1'b1), .i_irq_line_sample(irq_s), .o_line(line));
  ecpf_periph_model ecpf_periph_model_i (.i_mclk(i_mclk), .i_line(line), .o_busy(busy),
    .o_ack_n(ack_n), .o_pd(mpd));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and pulse counters; pulses last one cycle so they are counted on every rising edge
  initial forever #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (svc_irq === 1'b1) n_svc <= n_svc + 1;
    if (flt_irq === 1'b1) n_flt <= n_flt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and comparison
  task automatic report_and_stop();
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one-cycle strobes launched on the falling edge, answer sampled one cycle later
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic dm = 0);
    @(negedge i_mclk);
    host = '{1'b1, 1'b0, dm, dm, a, d};
    @(negedge i_mclk);
    host = '0;
  endtask
  task automatic rdc(input logic [10:0] a, input logic [7:0] e);
    @(negedge i_mclk);
    host = '{1'b0, 1'b1, 1'b0, 1'b0, a, 8'h00};
    @(negedge i_mclk);
    host = '0;
    chk({1'b0, rdata}, {1'b0, e});
  endtask
  // bounded wait on the peripheral's byte counters
  task automatic wait_for(input int n, input logic tx);
    for (int i = 0; i < 600 && (tx ? ecpf_periph_model_i.n_tx : ecpf_periph_model_i.n_rx) < n;
         i++) @(negedge i_mclk);
    if ((tx ? ecpf_periph_model_i.n_tx : ecpf_periph_model_i.n_rx) < n) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    rdc(ecpf_pkg::OFF_ECR, 8'h05);
    chk(9'(dreq), 9'h000);
    wr(ecpf_pkg::OFF_ECR, 8'hE4);
    rdc(ecpf_pkg::OFF_FIFO, 8'h10);
    // irq line toggles so its level must pass through the synchroniser before the read
    for (int c = 0; c < 8; c++) begin
      irq_s = c[0];
      wr(ecpf_pkg::OFF_CFGB, {2'b11, c[2:0], 3'b000});
      @(negedge i_mclk);
      rdc(ecpf_pkg::OFF_CFGB, {1'b0, c[0], c[2:0], 3'b111});
    end
    wr(ecpf_pkg::OFF_ECR, 8'h64);
    rdc(ecpf_pkg::OFF_ECR, 8'hE5);
    rdc(ecpf_pkg::OFF_STATUS, 8'hFF);
    // test mode: fill past full, drain all but one, then mode 000 must clear it
    wr(ecpf_pkg::OFF_ECR, 8'h04);
    wr(ecpf_pkg::OFF_ECR, 8'hC4);
    for (int i = 0; i < 17; i++) wr(ecpf_pkg::OFF_FIFO, 8'hA0 + i[7:0]);
    rdc(ecpf_pkg::OFF_ECR, 8'hC6);
    chk(9'(line.strobe_n), 9'h001);
    for (int i = 0; i < 15; i++) rdc(ecpf_pkg::OFF_FIFO, 8'hA0 + i[7:0]);
    wr(ecpf_pkg::OFF_ECR, 8'h04);
    wr(ecpf_pkg::OFF_ECR, 8'hC4);
    rdc(ecpf_pkg::OFF_ECR, 8'hC5);
    // forward transfers in modes 010 and 011
    wr(ecpf_pkg::OFF_ECR, 8'h04);
    wr(ecpf_pkg::OFF_ECR, 8'h44);
    for (int i = 0; i < 3; i++) wr(ecpf_pkg::OFF_FIFO, 8'h11 * (i[7:0] + 8'h01));
    wait_for(3, 1'b0);
    wr(ecpf_pkg::OFF_ECR, 8'h04);
    wr(ecpf_pkg::OFF_ECR, 8'h64);
    wr(ecpf_pkg::OFF_DATA, 8'hA5);
    wr(ecpf_pkg::OFF_FIFO, 8'h3C);
    wait_for(5, 1'b0);
    for (int i = 0; i < 5; i++) chk(ecpf_periph_model_i.rx[i], fexp[i]);
    // fault edge, then mask set and cleared while the fault is still low
    fault_n = 1'b0;
    repeat (8) @(negedge i_mclk);
    wr(ecpf_pkg::OFF_ECR, 8'h74);
    wr(ecpf_pkg::OFF_ECR, 8'h64);
    repeat (3) @(negedge i_mclk);
    chk(9'(n_flt), 9'h002);
    fault_n = 1'b1;
    // reverse collection, then mode 001 reading the line levels
    wr(ecpf_pkg::OFF_ECR, 8'h04);
    wr(ecpf_pkg::OFF_CONTROL, 8'h20);
    wr(ecpf_pkg::OFF_ECR, 8'h64);
    wait_for(2, 1'b1);
    rdc(ecpf_pkg::OFF_FIFO, 8'h50);
    rdc(ecpf_pkg::OFF_FIFO, 8'h51);
    rdc(ecpf_pkg::OFF_CONTROL, 8'hE0);
    wr(ecpf_pkg::OFF_ECR, 8'h24);
    repeat (10) @(negedge i_mclk);
    chk(9'(line.pd_oe), 9'h000);
    rdc(ecpf_pkg::OFF_DATA, ~(8'h50 + ecpf_periph_model_i.n_tx[7:0]));
    wr(ecpf_pkg::OFF_CONTROL, 8'h00);
    wr(ecpf_pkg::OFF_ECR, 8'h04);
    // dma request, terminal count, software clear and threshold service
    wr(ecpf_pkg::OFF_ECR, 8'hC8);
    chk(9'(dreq), 9'h001);
    wr(ecpf_pkg::OFF_FIFO, 8'h77, 1'b1);
    rdc(ecpf_pkg::OFF_ECR, 8'hCC);
    chk(9'(dreq), 9'h000);
    chk(9'(n_svc), 9'h001);
    wr(ecpf_pkg::OFF_ECR, 8'hC0);
    chk(9'(dreq), 9'h000);
    rdc(ecpf_pkg::OFF_FIFO, 8'h77);
    rdc(ecpf_pkg::OFF_ECR, 8'hC5);
    chk(9'(n_svc), 9'h002);
    // enhanced protocol without the option, then the reserved code, then with the option
    wr(ecpf_pkg::OFF_ECR, 8'h04);
    wr(ecpf_pkg::OFF_ECR, 8'h84);
    chk(9'(epp), 9'h000);
    epp_opt = 1'b1;
    wr(ecpf_pkg::OFF_ECR, 8'h04);
    wr(ecpf_pkg::OFF_ECR, 8'hA4);
    rdc(ecpf_pkg::OFF_ECR, 8'hA5);
    chk(9'(epp), 9'h000);
    wr(ecpf_pkg::OFF_ECR, 8'h04);
    wr(ecpf_pkg::OFF_ECR, 8'h84);
    chk(9'(epp), 9'h001);
    report_and_stop();
  end
endmodule
